// ### hdl/pasr_pkg.sv
// package: register map, field positions, masks, zero constants and carrier types
package pasr_pkg;
    localparam logic [5:0] OFS_PARTNER = 6'h05;
    localparam logic [5:0] OFS_EXPANSION = 6'h06;
    localparam logic [5:0] OFS_VENDOR = 6'h10;
    // partner ability word, field positions
    localparam int PA_NEXT_PAGE = 15;
    localparam int PA_ACK = 14;
    localparam int PA_FAULT = 13;
    localparam int PA_PAUSE = 10;
    localparam int PA_T4 = 9;
    localparam int PA_FAST_FDX = 8;
    localparam int PA_FAST_HDX = 7;
    localparam int PA_TEN_FDX = 6;
    localparam int PA_TEN_HDX = 5;
    // bits 12..11 reserved
    localparam logic [15:0] PA_KEEP_MASK = 16'hE7FF;
    // expansion field positions
    localparam int EX_PDF = 4;
    localparam int EX_LP_NP = 3;
    localparam int EX_NP = 2;
    localparam int EX_PAGE = 1;
    localparam int EX_LP_AN = 0;
    // vendor config field positions
    localparam int VC_NIBBLE = 15;
    localparam int VC_SCR = 14;
    localparam int VC_ALIGN = 13;
    localparam int VC_ADPOK = 12;
    localparam int VC_REPEATER = 11;
    localparam int VC_FAST = 10;
    localparam int VC_RSVD9 = 9;
    localparam int VC_RMII = 8;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [1:0] ZERO2 = 2'h0;

    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [31:0] writedata;
    } pasr_bus_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } pasr_bus_rsp_t;

    // events from the auto-negotiation engine
    typedef struct packed {
        logic wordValid;
        logic [15:0] word;
        logic partnerAnAble;
        logic pageReceived;
        logic parallelFault;
    } pasr_an_evt_t;

    // controls toward the datapath
    typedef struct packed {
        logic nibbleCodeSkip;
        logic scramblerSkip;
        logic symbolAlignSkip;
        logic adaptationOkSkip;
        logic repeaterMode;
        logic fastMode;
        logic reducedMii;
    } pasr_ctl_t;
endpackage

// ### hdl/pasr_regs.sv
// auto-negotiation result and vendor configuration registers on avalon-mm
`timescale 1ns/100ps
`default_nettype none
module pasr_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register bus
    input wire pasr_pkg::pasr_bus_req_t busReq,
    output pasr_pkg::pasr_bus_rsp_t busRsp,
    // auto-negotiation engine
    input wire pasr_pkg::pasr_an_evt_t anEvt,
    // strap pins
    input wire logic repeaterStrap,
    input wire logic reducedMiiStrap,
    // datapath controls
    output pasr_pkg::pasr_ctl_t ctl
);
    import pasr_pkg::*;

    typedef struct packed {
        logic strapsTaken;
        logic [15:0] partnerAbility;
        logic partnerNpCapable;
        logic partnerAnCapable;
        logic nibbleCodeSkip;
        logic scramblerSkip;
        logic symbolAlignSkip;
        logic adaptationOkSkip;
        logic repeaterMode;
        logic fastMode;
        logic reducedMii;
        logic busy;
        logic waitreq;
        logic [31:0] readdata;
    } pasr_regs_t;

    pasr_regs_t state_q;
    pasr_regs_t state_d;
    logic [1:0] rstSync_q;
    logic rstN;
    logic start;
    logic faultFlag;
    logic pageFlag;
    logic readExpansion;
    logic accept;
    logic [15:0] expansionWord;
    logic [15:0] vendorWord;
    logic [15:0] readWord;

    // reset release through two flip-flops; only the second feeds the design
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= ZERO2;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // a request is answered in the cycle after it appears, one wait state;
    // read data and the read-clear of the flags are taken at the start edge
    assign start = (busReq.read || busReq.write) && !state_q.busy;
    assign accept = (busReq.read || busReq.write) && state_q.busy;
    assign readExpansion = start && busReq.read && (busReq.address == OFS_EXPANSION);

    pasr_sticky u_fault (
        .clk(ref_clk),
        .rstN(rstN),
        .setPulse(anEvt.parallelFault),
        .clrPulse(readExpansion),
        .flag(faultFlag)
    );

    pasr_sticky u_page (
        .clk(ref_clk),
        .rstN(rstN),
        .setPulse(anEvt.pageReceived),
        .clrPulse(readExpansion),
        .flag(pageFlag)
    );

    always_comb begin
        expansionWord = ZERO16;
        expansionWord[EX_PDF] = faultFlag;
        expansionWord[EX_LP_NP] = state_q.partnerNpCapable;
        expansionWord[EX_NP] = 1'b0;
        expansionWord[EX_PAGE] = pageFlag;
        expansionWord[EX_LP_AN] = state_q.partnerAnCapable;
    end

    always_comb begin
        vendorWord = ZERO16;
        vendorWord[VC_NIBBLE] = state_q.nibbleCodeSkip;
        vendorWord[VC_SCR] = state_q.scramblerSkip;
        vendorWord[VC_ALIGN] = state_q.symbolAlignSkip;
        vendorWord[VC_ADPOK] = state_q.adaptationOkSkip;
        vendorWord[VC_REPEATER] = state_q.repeaterMode;
        vendorWord[VC_FAST] = state_q.fastMode;
        vendorWord[VC_RSVD9] = 1'b1;
        vendorWord[VC_RMII] = state_q.reducedMii;
    end

    always_comb begin
        unique case (busReq.address)
            OFS_PARTNER: begin
                readWord = state_q.partnerAbility & PA_KEEP_MASK;
            end
            OFS_EXPANSION: begin
                readWord = expansionWord;
            end
            OFS_VENDOR: begin
                readWord = vendorWord;
            end
            default: begin
                readWord = ZERO16;
            end
        endcase
    end

    always_comb begin
        state_d = state_q;
        // partner word less reserved bits 12..11, including ack, next page, fault, pause, selector
        if (anEvt.wordValid) begin
            state_d.partnerAbility = anEvt.word & PA_KEEP_MASK;
        end
        state_d.partnerAnCapable = anEvt.partnerAnAble;
        state_d.partnerNpCapable = state_d.partnerAbility[PA_NEXT_PAGE];
        // straps are caught once, on the first clock after reset release
        if (!state_q.strapsTaken) begin
            state_d.strapsTaken = 1'b1;
            state_d.repeaterMode = repeaterStrap;
            state_d.reducedMii = reducedMiiStrap;
        end
        state_d.busy = 1'b0;
        state_d.waitreq = 1'b1;
        if (start) begin
            state_d.busy = 1'b1;
            state_d.waitreq = 1'b0;
            state_d.readdata = ZERO32;
            if (busReq.read) begin
                state_d.readdata = {ZERO16, readWord};
            end
        end
        if (accept) begin
            // only the vendor register takes writes; read-only words ignore them
            if (busReq.write && busReq.address == OFS_VENDOR) begin
                state_d.nibbleCodeSkip = busReq.writedata[VC_NIBBLE];
                state_d.scramblerSkip = busReq.writedata[VC_SCR];
                state_d.symbolAlignSkip = busReq.writedata[VC_ALIGN];
                state_d.adaptationOkSkip = busReq.writedata[VC_ADPOK];
                state_d.repeaterMode = busReq.writedata[VC_REPEATER];
                state_d.fastMode = busReq.writedata[VC_FAST];
                state_d.reducedMii = busReq.writedata[VC_RMII];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state_q.strapsTaken <= 1'b0;
            state_q.partnerAbility <= ZERO16;
            state_q.partnerNpCapable <= 1'b0;
            state_q.partnerAnCapable <= 1'b0;
            state_q.nibbleCodeSkip <= 1'b0;
            state_q.scramblerSkip <= 1'b0;
            state_q.symbolAlignSkip <= 1'b0;
            state_q.adaptationOkSkip <= 1'b1;
            state_q.repeaterMode <= 1'b0;
            state_q.fastMode <= 1'b1;
            state_q.reducedMii <= 1'b0;
            state_q.busy <= 1'b0;
            state_q.waitreq <= 1'b1;
            state_q.readdata <= ZERO32;
        end else begin
            state_q.strapsTaken <= state_d.strapsTaken;
            state_q.partnerAbility <= state_d.partnerAbility;
            state_q.partnerNpCapable <= state_d.partnerNpCapable;
            state_q.partnerAnCapable <= state_d.partnerAnCapable;
            state_q.nibbleCodeSkip <= state_d.nibbleCodeSkip;
            state_q.scramblerSkip <= state_d.scramblerSkip;
            state_q.symbolAlignSkip <= state_d.symbolAlignSkip;
            state_q.adaptationOkSkip <= state_d.adaptationOkSkip;
            state_q.repeaterMode <= state_d.repeaterMode;
            state_q.fastMode <= state_d.fastMode;
            state_q.reducedMii <= state_d.reducedMii;
            state_q.busy <= state_d.busy;
            state_q.waitreq <= state_d.waitreq;
            state_q.readdata <= state_d.readdata;
        end
    end

    assign busRsp.waitrequest = state_q.waitreq;
    assign busRsp.readdata = state_q.readdata;
    assign ctl.nibbleCodeSkip = state_q.nibbleCodeSkip;
    assign ctl.scramblerSkip = state_q.scramblerSkip;
    assign ctl.symbolAlignSkip = state_q.symbolAlignSkip;
    assign ctl.adaptationOkSkip = state_q.adaptationOkSkip;
    assign ctl.repeaterMode = state_q.repeaterMode;
    assign ctl.fastMode = state_q.fastMode;
    assign ctl.reducedMii = state_q.reducedMii;

    chk_partner_word: assert property (@(posedge ref_clk) disable iff (!rstN)
        anEvt.wordValid |=> state_q.partnerAbility == ($past(anEvt.word) & PA_KEEP_MASK))
        else $error("partner word not captured");
    chk_ack_follows: assert property (@(posedge ref_clk) disable iff (!rstN)
        !anEvt.wordValid |=> $stable(state_q.partnerAbility[PA_ACK]))
        else $error("acknowledge changed without a word");
    chk_next_page_word: assert property (@(posedge ref_clk) disable iff (!rstN)
        anEvt.wordValid |=> state_q.partnerAbility[PA_NEXT_PAGE] == $past(anEvt.word[PA_NEXT_PAGE]))
        else $error("next page bit not captured");
    chk_fault_word: assert property (@(posedge ref_clk) disable iff (!rstN)
        anEvt.wordValid |=> state_q.partnerAbility[PA_FAULT] == $past(anEvt.word[PA_FAULT]))
        else $error("remote fault bit not captured");
    chk_pause_word: assert property (@(posedge ref_clk) disable iff (!rstN)
        anEvt.wordValid |=> state_q.partnerAbility[PA_PAUSE] == $past(anEvt.word[PA_PAUSE]))
        else $error("pause bit not captured");
    chk_tech_word: assert property (@(posedge ref_clk) disable iff (!rstN)
        anEvt.wordValid |=> state_q.partnerAbility[PA_T4:PA_TEN_HDX] == $past(anEvt.word[PA_T4:PA_TEN_HDX]))
        else $error("technology bits not captured");
    chk_selector_word: assert property (@(posedge ref_clk) disable iff (!rstN)
        anEvt.wordValid |=> state_q.partnerAbility[PA_TEN_HDX - 1:0] == $past(anEvt.word[PA_TEN_HDX - 1:0]))
        else $error("selector field not captured");
    chk_ro_write: assert property (@(posedge ref_clk) disable iff (!rstN)
        (accept && busReq.write && !anEvt.wordValid) |=> $stable(state_q.partnerAbility))
        else $error("write changed read-only register");

    chk_partner_read: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address == OFS_PARTNER)
            |=> busRsp.readdata == {ZERO16, $past(state_q.partnerAbility)})
        else $error("partner read data wrong");
    chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address == OFS_PARTNER) |=> busRsp.readdata[12:11] == ZERO2)
        else $error("reserved partner bits not zero");
    chk_expansion_hi: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address == OFS_EXPANSION) |=> busRsp.readdata[15:5] == 11'h000)
        else $error("reserved expansion bits not zero");
    chk_np_zero: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address == OFS_EXPANSION) |=> !busRsp.readdata[EX_NP])
        else $error("local next page bit set");
    chk_lp_np_read: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address == OFS_EXPANSION)
            |=> busRsp.readdata[EX_LP_NP] == $past(state_q.partnerNpCapable))
        else $error("partner next page capable not reported");
    chk_an_read: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address == OFS_EXPANSION)
            |=> busRsp.readdata[EX_LP_AN] == $past(state_q.partnerAnCapable))
        else $error("partner autoneg capable not reported");
    chk_fault_read: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address == OFS_EXPANSION) |=> busRsp.readdata[EX_PDF] == $past(faultFlag))
        else $error("fault flag not reported");
    chk_page_read: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address == OFS_EXPANSION) |=> busRsp.readdata[EX_PAGE] == $past(pageFlag))
        else $error("page flag not reported");
    chk_reserved_one: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address == OFS_VENDOR) |=> busRsp.readdata[VC_RSVD9])
        else $error("vendor reserved bit not one");
    chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rstN)
        (start && busReq.read && busReq.address != OFS_PARTNER && busReq.address != OFS_EXPANSION
            && busReq.address != OFS_VENDOR) |=> busRsp.readdata == ZERO32)
        else $error("unmapped read not zero");

    chk_fault_set: assert property (@(posedge ref_clk) disable iff (!rstN)
        anEvt.parallelFault |=> faultFlag)
        else $error("fault flag not set");
    chk_page_set: assert property (@(posedge ref_clk) disable iff (!rstN)
        anEvt.pageReceived |=> pageFlag)
        else $error("page flag not set");
    chk_fault_hold: assert property (@(posedge ref_clk) disable iff (!rstN)
        (faultFlag && !readExpansion) |=> faultFlag)
        else $error("fault flag dropped without read");
    chk_fault_clear: assert property (@(posedge ref_clk) disable iff (!rstN)
        (readExpansion && !anEvt.parallelFault) |=> !faultFlag)
        else $error("fault flag not cleared on read");
    chk_page_hold: assert property (@(posedge ref_clk) disable iff (!rstN)
        (pageFlag && !readExpansion) |=> pageFlag)
        else $error("page flag dropped without read");
    chk_page_clear: assert property (@(posedge ref_clk) disable iff (!rstN)
        (readExpansion && !anEvt.pageReceived) |=> !pageFlag)
        else $error("page flag not cleared on read");
    chk_an_able: assert property (@(posedge ref_clk) disable iff (!rstN)
        1'b1 |=> state_q.partnerAnCapable == $past(anEvt.partnerAnAble))
        else $error("autoneg capable not followed");
    chk_flag_write: assert property (@(posedge ref_clk) disable iff (!rstN)
        (accept && busReq.write && !anEvt.pageReceived && !anEvt.parallelFault)
            |=> $stable(pageFlag) && $stable(faultFlag))
        else $error("write changed expansion flags");

    chk_vendor_write: assert property (@(posedge ref_clk) disable iff (!rstN)
        (accept && busReq.write && busReq.address == OFS_VENDOR)
        |=> ctl.scramblerSkip == $past(busReq.writedata[VC_SCR])
            && ctl.nibbleCodeSkip == $past(busReq.writedata[VC_NIBBLE]))
        else $error("vendor write not applied");
    chk_align_write: assert property (@(posedge ref_clk) disable iff (!rstN)
        (accept && busReq.write && busReq.address == OFS_VENDOR)
            |=> ctl.symbolAlignSkip == $past(busReq.writedata[VC_ALIGN]))
        else $error("alignment skip not written");
    chk_repeater_write: assert property (@(posedge ref_clk) disable iff (!rstN)
        (accept && busReq.write && busReq.address == OFS_VENDOR)
            |=> ctl.repeaterMode == $past(busReq.writedata[VC_REPEATER]))
        else $error("repeater bit not written");
    chk_fast_write: assert property (@(posedge ref_clk) disable iff (!rstN)
        (accept && busReq.write && busReq.address == OFS_VENDOR)
            |=> ctl.fastMode == $past(busReq.writedata[VC_FAST]))
        else $error("fast mode bit not written");
    chk_rmii_write: assert property (@(posedge ref_clk) disable iff (!rstN)
        (accept && busReq.write && busReq.address == OFS_VENDOR)
            |=> ctl.reducedMii == $past(busReq.writedata[VC_RMII]))
        else $error("reduced interface bit not written");
    chk_vendor_hold: assert property (@(posedge ref_clk) disable iff (!rstN)
        (state_q.strapsTaken && !(accept && busReq.write && busReq.address == OFS_VENDOR))
            |=> $stable(ctl))
        else $error("controls changed without a write");
    chk_strap_repeater: assert property (@(posedge ref_clk) disable iff (!rstN)
        !state_q.strapsTaken |=> ctl.repeaterMode == $past(repeaterStrap))
        else $error("repeater strap not captured");
    chk_strap_rmii: assert property (@(posedge ref_clk) disable iff (!rstN)
        !state_q.strapsTaken |=> ctl.reducedMii == $past(reducedMiiStrap))
        else $error("reduced interface strap not captured");

    chk_one_wait: assert property (@(posedge ref_clk) disable iff (!rstN)
        ((busReq.read || busReq.write) && busRsp.waitrequest) |=> !busRsp.waitrequest)
        else $error("request not answered in one cycle");
    chk_rsp_pulse: assert property (@(posedge ref_clk) disable iff (!rstN)
        !busRsp.waitrequest |=> busRsp.waitrequest)
        else $error("answer stood longer than one cycle");
endmodule
`default_nettype wire

// ### hdl/pasr_sticky.sv
// sticky flag that sets from hardware and clears when read; the set wins
`timescale 1ns/100ps
`default_nettype none
module pasr_sticky (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // set and clear
    input wire logic setPulse,
    input wire logic clrPulse,
    // state
    output logic flag
);
    typedef struct packed {
        logic flag;
    } pasr_sticky_t;

    pasr_sticky_t state_q;
    pasr_sticky_t state_d;

    always_comb begin
        state_d = state_q;
        if (setPulse) begin
            state_d.flag = 1'b1;
        end else if (clrPulse) begin
            state_d.flag = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign flag = state_q.flag;

    chk_set_wins: assert property (@(posedge clk) disable iff (!rstN)
        setPulse |=> flag) else $error("sticky flag lost a set");
    chk_clear_read: assert property (@(posedge clk) disable iff (!rstN)
        (clrPulse && !setPulse) |=> !flag) else $error("sticky flag not cleared");
endmodule
`default_nettype wire

// ### tb/pasr_mgmt_model.sv
// station management master model speaking avalon-mm to the register block
`timescale 1ns/100ps
`default_nettype none
module pasr_mgmt_model (
    // clock
    input wire logic ref_clk,
    // register bus
    output pasr_pkg::pasr_bus_req_t busReq,
    input wire pasr_pkg::pasr_bus_rsp_t busRsp
);
    import pasr_pkg::*;

    initial busReq = '0;

    // one transfer: launch after an edge, hold until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [5:0] addr, input logic [15:0] data, output logic [15:0] q);
        @(posedge ref_clk);
        busReq <= '{read: ~wr, write: wr, address: addr, writedata: {16'h0000, data}};
        @(posedge ref_clk);
        // only the bench timeout ends a wait that never finishes
        while (busRsp.waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        q = busRsp.readdata[15:0];
        // released lines show the inverse so stale values cannot pass
        busReq <= '{read: 1'b0, write: 1'b0, address: ~addr, writedata: ~{16'h0000, data}};
    endtask
endmodule
`default_nettype wire

// ### tb/pasr_regs_test.sv
// self-checking testbench for the auto-negotiation and vendor configuration registers
`timescale 1ns/100ps
`default_nettype none
module pasr_regs_test;
    import pasr_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    pasr_bus_req_t busReq;
    pasr_bus_rsp_t busRsp;
    pasr_an_evt_t anEvt = '0;
    logic repeaterStrap = 1'b0;
    logic reducedMiiStrap = 1'b0;
    pasr_ctl_t ctl;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    logic [15:0] rd;
    logic [15:0] w;
    logic [15:0] vend;
    logic pg, pf, an;

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    pasr_regs DUT (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .busReq(busReq),
        .busRsp(busRsp),
        .anEvt(anEvt),
        .repeaterStrap(repeaterStrap),
        .reducedMiiStrap(reducedMiiStrap),
        .ctl(ctl)
    );

    pasr_mgmt_model mgr (
        .ref_clk(ref_clk),
        .busReq(busReq),
        .busRsp(busRsp)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmpCtl(input pasr_ctl_t got, input pasr_ctl_t exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: controls got %b expected %b", $time, got, exp);
        end
    endtask

    function automatic pasr_ctl_t ctlOf(input logic [15:0] v);
        return '{v[15], v[14], v[13], v[12], v[11], v[10], v[8]};
    endfunction

    task automatic rdReg(input logic [5:0] a);
        mgr.xfer(1'b0, a, 16'h0000, rd);
    endtask

    task automatic wrReg(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] q;
        mgr.xfer(1'b1, a, d, q);
    endtask

    // one engine event: code word plus flag pulses and the capability level
    task automatic sendEvt(input logic [15:0] word, input logic page, input logic fault, input logic able);
        @(posedge ref_clk);
        anEvt <= '{wordValid: 1'b1, word: word, partnerAnAble: able, pageReceived: page, parallelFault: fault};
        @(posedge ref_clk);
        anEvt.wordValid <= 1'b0;
        anEvt.pageReceived <= 1'b0;
        anEvt.parallelFault <= 1'b0;
    endtask

    task automatic doReset();
        reset_n <= 1'b0;
        repeaterStrap <= 1'($urandom);
        reducedMiiStrap <= 1'($urandom);
        anEvt <= '0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        vend = {4'h1, repeaterStrap, 2'b11, reducedMiiStrap, 8'h00};
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            $display("unexpected at %0t: timeout", $time);
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(32'hDA2F));
        for (int r = 0; r < 2; r++) begin
            doReset();
            rdReg(OFS_PARTNER);
            cmp16(rd, 16'h0000, "partner reset");
            rdReg(OFS_EXPANSION);
            cmp16(rd, 16'h0000, "expansion reset");
            rdReg(OFS_VENDOR);
            cmp16(rd, vend, "vendor reset");
            cmpCtl(ctl, ctlOf(vend));
            wrReg(6'h07, 16'hFFFF);
            rdReg(6'h07);
            cmp16(rd, 16'h0000, "unmapped");
            $display("reset values round %0d done", r);
            for (int i = 0; i < 8; i++) begin
                w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
                sendEvt(w, 1'b0, 1'b0, 1'b0);
                wrReg(OFS_PARTNER, ~w);
                rdReg(OFS_PARTNER);
                cmp16(rd, w & 16'hE7FF, "partner word");
            end
            rdReg(OFS_EXPANSION);
            $display("partner ability round %0d done", r);
            for (int i = 0; i < 8; i++) begin
                w = 16'($urandom);
                pg = (i == 0) ? 1'b1 : 1'($urandom);
                pf = (i == 0) ? 1'b1 : 1'($urandom);
                an = 1'($urandom);
                sendEvt(w, pg, pf, an);
                wrReg(OFS_EXPANSION, 16'hFFFF);
                rdReg(OFS_EXPANSION);
                cmp16(rd, {11'h000, pf, w[15], 1'b0, pg, an}, "expansion flags");
                rdReg(OFS_EXPANSION);
                cmp16(rd, {11'h000, 1'b0, w[15], 1'b0, 1'b0, an}, "expansion cleared");
            end
            $display("expansion round %0d done", r);
            for (int i = 0; i < 10; i++) begin
                w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
                wrReg(OFS_VENDOR, w);
                vend = (w & 16'hFD00) | 16'h0200;
                rdReg(OFS_VENDOR);
                cmp16(rd, vend, "vendor readback");
                cmpCtl(ctl, ctlOf(vend));
            end
            $display("vendor config round %0d done", r);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
